/* File: src/slmon_defines.vh */
// Constants shared by the serial link enable and alarm monitor
`ifndef SLMON_DEFINES_VH
`define SLMON_DEFINES_VH

// Alarm status bit positions
`define SLMON_ALM_CPLL 0
`define SLMON_ALM_SPLL 1
`define SLMON_ALM_LINK 2
`define SLMON_ALM_REALIGN 3
`define SLMON_ALM_CLOCK 4
`define SLMON_ALM_FIFO 5
`define SLMON_ALM_W 6

// Reset values
`define SLMON_ALM_RESET 6'h00
`define SLMON_MASK_NONE 6'h00

// Link states
`define SLMON_ST_OFF 2'h0
`define SLMON_ST_CGS 2'h1
`define SLMON_ST_ILAS 2'h2
`define SLMON_ST_DATA 2'h3

// Timing defaults, in clock cycles, frames and multiframes
`define SLMON_FRAME_DIV 4
`define SLMON_MF_LEN_8B 32
`define SLMON_EMB_LEN_64B 64
`define SLMON_ILAS_MF 4

`endif

/* File: src/slmon_skid.v */
// Two-entry buffer with registered ready for the sample stream
`timescale 1ns/100ps
module slmon_skid
#(
   parameter DW = 32
)
(
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_flush,
   input wire i_accept_en,
   input wire [DW-1:0] i_data,
   input wire i_valid,
   output reg o_ready,
   output reg [DW-1:0] o_data,
   output reg o_valid,
   input wire i_ready
);
   reg [DW-1:0] spare;
   reg spare_full;
   wire push;
   wire pop;
   wire [1:0] count;
   reg [1:0] next_count;

   assign push = i_valid & o_ready;
   assign pop = o_valid & i_ready;
   assign count = {1'b0, o_valid} + {1'b0, spare_full};

   always @*
   begin
      next_count = count;
      if (push & ~pop)
         next_count = count + 2'h1;
      else if (pop & ~push)
         next_count = count - 2'h1;
   end

   always @(posedge i_sys_clk)
   begin
      if (i_rst | i_flush)
      begin
         o_valid <= 1'b0;
         spare_full <= 1'b0;
         o_ready <= 1'b0;
         o_data <= {DW{1'b0}};
         spare <= {DW{1'b0}};
      end
      else
      begin
         // Ready is registered from next_count, so it is high only when the buffer will be empty and no word lands after the stall starts
         o_ready <= i_accept_en & (next_count == 2'h0);
         if (pop | ~o_valid)
         begin
            if (spare_full)
            begin
               o_data <= spare;
               o_valid <= 1'b1;
               spare_full <= push;
               spare <= i_data;
            end
            else
            begin
               o_data <= i_data;
               o_valid <= push;
            end
         end
         else if (push)
         begin
            spare <= i_data;
            spare_full <= 1'b1;
         end
      end
   end
endmodule // slmon_skid

/* File: src/slmon_top.v */
// Serial link enable, local multiframe timing and alarm monitor
//
// How it works
// - Enable low: reset, serializer powerdown, clock gate.
// - Enable high releases block and starts link.
// - In subclass 1, SYSREF resets multiframe or extended multiblock counter.
// - Subclass 0 free-runs local multiframe counter.
// - In 8b/10b mode, SYNC request starts CGS then ILAS.
// - Six alarm sources are detected.
// - Each alarm sets its own status bit.
// - Status bits sticky, cleared by writing one.
// - Unmasked alarms raise the summary flag.
// - Status pin shows alarm when selected.
// - Channel A/B clock mismatch sets clock alarm while both channels powered.
// - Lane FIFO upset sets that lane's alarm.
// - Enable toggle resets link state, counters and output buffer, not lane FIFO alarms.
`timescale 1ns/100ps
`include "slmon_defines.vh"
module slmon_top
#(
   parameter LANES = 8,
   parameter DW = 32,
   parameter FRAME_DIV = `SLMON_FRAME_DIV,
   parameter MF_LEN_8B = `SLMON_MF_LEN_8B,
   parameter EMB_LEN_64B = `SLMON_EMB_LEN_64B,
   parameter ILAS_MF = `SLMON_ILAS_MF
)
(
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_link_enable,
   input wire i_sel_8b10b,
   input wire i_subclass1,
   input wire i_sysref,
   input wire i_sync_n,
   input wire i_cpll_locked,
   input wire i_spll_locked,
   input wire i_chan_a_clk,
   input wire i_chan_b_clk,
   input wire i_powerdown_chan_a,
   input wire i_powerdown_chan_b,
   input wire [LANES-1:0] i_lane_fifo_err,
   input wire [`SLMON_ALM_W-1:0] i_alarm_status_clear,
   input wire [LANES-1:0] i_lane_fifo_alarm_clear,
   input wire [`SLMON_ALM_W-1:0] i_alarm_mask,
   input wire i_cal_status_sel_alarm,
   input wire i_cal_status_other,
   input wire [DW-1:0] i_data,
   input wire i_data_valid,
   output wire o_data_ready,
   output wire [DW-1:0] o_data,
   output wire o_data_valid,
   input wire i_data_ready,
   output reg o_link_reset,
   output reg o_serializer_powerdown,
   output reg o_link_clk_enable,
   output reg [1:0] o_link_state,
   output reg o_mf_edge,
   output reg [7:0] o_mf_count,
   output reg [`SLMON_ALM_W-1:0] o_alarm_status,
   output reg [LANES-1:0] o_lane_fifo_alarm,
   output reg o_alarm,
   output reg o_cal_status_pin
);
   ////////////////////////////////////////////////////////////////////////////
   // Frame and half-rate enables
   reg [7:0] frame_div;
   reg frame_en;
   reg half_en;
   reg [7:0] mf_len;
   reg [7:0] next_mf_count;
   reg sysref_hit;
   reg [7:0] ilas_cnt;
   reg [1:0] next_state;
   reg [`SLMON_ALM_W-1:0] alarm_event;
   reg [`SLMON_ALM_W-1:0] next_status;
   wire [LANES-1:0] next_lane_alarm;
   wire link_on;

   assign link_on = i_link_enable & ~o_link_reset;

   always @(posedge i_sys_clk)
   begin
      if (i_rst | ~link_on)
      begin
         frame_div <= 8'h00;
         frame_en <= 1'b0;
         half_en <= 1'b0;
      end
      else
      begin
         half_en <= ~half_en;
         frame_en <= (frame_div == FRAME_DIV[7:0] - 8'h01);
         if (frame_div == FRAME_DIV[7:0] - 8'h01)
            frame_div <= 8'h00;
         else
            frame_div <= frame_div + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Local multiframe / extended multiblock counter
   always @*
   begin
      mf_len = i_sel_8b10b ? MF_LEN_8B[7:0] : EMB_LEN_64B[7:0];
      sysref_hit = i_subclass1 & i_sysref & link_on;
      next_mf_count = o_mf_count;
      if (sysref_hit)
         next_mf_count = 8'h00;
      else if (frame_en)
      begin
         // Without SYSREF the phase is whatever the release left it at
         if (o_mf_count == mf_len - 8'h01)
            next_mf_count = 8'h00;
         else
            next_mf_count = o_mf_count + 8'h01;
      end
   end

   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_link_reset <= 1'b1;
         o_serializer_powerdown <= 1'b1;
         o_link_clk_enable <= 1'b0;
         o_mf_count <= 8'h00;
         o_mf_edge <= 1'b0;
      end
      else
      begin
         o_link_reset <= ~i_link_enable;
         o_serializer_powerdown <= ~i_link_enable;
         o_link_clk_enable <= i_link_enable;
         o_mf_count <= link_on ? next_mf_count : 8'h00;
         o_mf_edge <= link_on & frame_en & (next_mf_count == 8'h00);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link state (8b/10b): CGS while SYNC is low, ILAS from a multiframe edge, then data
   always @*
   begin
      next_state = o_link_state;
      case (o_link_state)
         `SLMON_ST_OFF:
            if (link_on)
               next_state = i_sel_8b10b ? `SLMON_ST_CGS : `SLMON_ST_DATA;
         `SLMON_ST_CGS:
            if (~i_sync_n)
               next_state = `SLMON_ST_CGS;
            else if (o_mf_edge)
               next_state = `SLMON_ST_ILAS;
         `SLMON_ST_ILAS:
            if (~i_sync_n)
               next_state = `SLMON_ST_CGS;
            else if (o_mf_edge & (ilas_cnt == ILAS_MF[7:0] - 8'h01))
               next_state = `SLMON_ST_DATA;
         default:
            if (i_sel_8b10b & ~i_sync_n)
               next_state = `SLMON_ST_CGS;
      endcase
      if (~link_on)
         next_state = `SLMON_ST_OFF;
   end

   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_link_state <= `SLMON_ST_OFF;
         ilas_cnt <= 8'h00;
      end
      else
      begin
         o_link_state <= next_state;
         if (o_link_state != `SLMON_ST_ILAS)
            ilas_cnt <= 8'h00;
         else if (o_mf_edge)
            ilas_cnt <= ilas_cnt + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alarm sources, sticky status and summary
   always @*
   begin
      alarm_event = `SLMON_ALM_RESET;
      alarm_event[`SLMON_ALM_CPLL] = ~i_cpll_locked;
      alarm_event[`SLMON_ALM_SPLL] = ~i_spll_locked;
      alarm_event[`SLMON_ALM_LINK] = link_on & (o_link_state != `SLMON_ST_DATA);
      // Only a SYSREF that moves the phase counts as a realignment
      alarm_event[`SLMON_ALM_REALIGN] = sysref_hit & (o_mf_count != 8'h00);
      // Compared on the device clock divided by two, both channels powered
      alarm_event[`SLMON_ALM_CLOCK] = link_on & half_en & ~i_powerdown_chan_a &
                                      ~i_powerdown_chan_b & (i_chan_a_clk != i_chan_b_clk);
      alarm_event[`SLMON_ALM_FIFO] = link_on & (|i_lane_fifo_err);
      // Set wins over a clear in the same cycle
      next_status = (o_alarm_status & ~i_alarm_status_clear) | alarm_event;
   end

   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1)
      begin : g_lane
         // A disabled link holds the lane FIFOs in reset, so no error is seen
         assign next_lane_alarm[g] = (o_lane_fifo_alarm[g] & ~i_lane_fifo_alarm_clear[g]) |
                                     (link_on & i_lane_fifo_err[g]);
      end
   endgenerate

   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_alarm_status <= `SLMON_ALM_RESET;
         o_lane_fifo_alarm <= {LANES{1'b0}};
         o_alarm <= 1'b0;
         o_cal_status_pin <= 1'b0;
      end
      else
      begin
         o_alarm_status <= next_status;
         o_lane_fifo_alarm <= next_lane_alarm;
         o_alarm <= |(next_status & ~i_alarm_mask);
         o_cal_status_pin <= i_cal_status_sel_alarm ?
                             |(next_status & ~i_alarm_mask) : i_cal_status_other;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sample stream buffer, open only in the data state
   slmon_skid #(
      .DW(DW)
   ) u_skid (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_flush(~link_on),
      .i_accept_en(next_state == `SLMON_ST_DATA),
      .i_data(i_data),
      .i_valid(i_data_valid),
      .o_ready(o_data_ready),
      .o_data(o_data),
      .o_valid(o_data_valid),
      .i_ready(i_data_ready)
   );
endmodule // slmon_top

/* File: verification/slmon_chk.sv */
// Port assertions for the link enable and alarm monitor
`timescale 1ns/100ps
module slmon_chk
#(
   parameter LANES = 8
)
(
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_link_enable,
   input wire i_subclass1,
   input wire i_sysref,
   input wire i_cpll_locked,
   input wire i_chan_a_clk,
   input wire i_chan_b_clk,
   input wire i_powerdown_chan_a,
   input wire i_powerdown_chan_b,
   input wire [LANES-1:0] i_lane_fifo_err,
   input wire [5:0] i_alarm_status_clear,
   input wire [5:0] i_alarm_mask,
   input wire i_cal_status_sel_alarm,
   input wire o_link_reset,
   input wire o_link_clk_enable,
   input wire [1:0] o_link_state,
   input wire [7:0] o_mf_count,
   input wire [5:0] o_alarm_status,
   input wire [LANES-1:0] o_lane_fifo_alarm,
   input wire o_alarm,
   input wire o_cal_status_pin
);
// Bits that must survive one more cycle; cleared with reset so a new run starts clean
reg [5:0] held;
always @(posedge i_sys_clk)
   held <= i_rst ? 6'h00 : o_alarm_status & ~i_alarm_status_clear;
default clocking @(posedge i_sys_clk); endclocking
default disable iff (i_rst);
sequence s_wake;
   !i_link_enable ##1 i_link_enable;
endsequence
// Two edges of skew always span one compare slot
sequence s_skew;
   (i_chan_a_clk != i_chan_b_clk && i_link_enable && !o_link_reset && !i_powerdown_chan_a
      && !i_powerdown_chan_b)[*2];
endsequence
////////////////////////////////////////
AST_OFF: assert property (!i_link_enable |=>
   o_link_reset && !o_link_clk_enable && o_link_state == 2'h0)
   else $error("link not held off");
AST_ON: assert property (s_wake |=> !o_link_reset && o_link_clk_enable)
   else $error("link not released");
AST_STICKY: assert property ((o_alarm_status & held) == held)
   else $error("alarm bit lost");
AST_SUM: assert property (o_alarm == |(o_alarm_status & ~$past(i_alarm_mask)))
   else $error("summary flag wrong");
AST_PIN: assert property (!$past(i_rst) && $past(i_cal_status_sel_alarm) |->
   o_cal_status_pin == o_alarm)
   else $error("status pin wrong");
AST_PLL: assert property (!i_cpll_locked |=> o_alarm_status[0])
   else $error("pll alarm missing");
AST_SREF: assert property (i_sysref && i_subclass1 && i_link_enable && !o_link_reset |=>
   o_mf_count == 8'h00 && (o_alarm_status[3] || $past(o_mf_count) == 8'h00))
   else $error("sysref reset wrong");
AST_UPSET: assert property (s_skew |-> ##[1:3] o_alarm_status[4])
   else $error("clock upset missed");
AST_LANE: assert property (i_link_enable && !o_link_reset && |i_lane_fifo_err |=>
   (o_lane_fifo_alarm & $past(i_lane_fifo_err)) == $past(i_lane_fifo_err)
   && o_alarm_status[5])
   else $error("lane alarm missing");
endmodule // slmon_chk

bind slmon_top slmon_chk #(.LANES(LANES)) u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
   .i_link_enable(i_link_enable), .i_subclass1(i_subclass1), .i_sysref(i_sysref),
   .i_cpll_locked(i_cpll_locked), .i_chan_a_clk(i_chan_a_clk), .i_chan_b_clk(i_chan_b_clk),
   .i_powerdown_chan_a(i_powerdown_chan_a), .i_powerdown_chan_b(i_powerdown_chan_b),
   .i_lane_fifo_err(i_lane_fifo_err), .i_alarm_status_clear(i_alarm_status_clear),
   .i_alarm_mask(i_alarm_mask), .i_cal_status_sel_alarm(i_cal_status_sel_alarm),
   .o_link_reset(o_link_reset), .o_link_clk_enable(o_link_clk_enable),
   .o_link_state(o_link_state), .o_mf_count(o_mf_count), .o_alarm_status(o_alarm_status),
   .o_lane_fifo_alarm(o_lane_fifo_alarm), .o_alarm(o_alarm), .o_cal_status_pin(o_cal_status_pin));

/* File: verification/slmon_rx_model.sv */
// Receiver stand-in: SYNC request and output stream ready
`timescale 1ns/100ps
module slmon_rx_model
#(
   parameter RBD = 0
)
(
   input wire i_sys_clk,
   input wire [1:0] i_mode,
   input wire i_resync,
   input wire i_mf_edge,
   input wire [1:0] i_link_state,
   output reg o_sync_n,
   output reg o_data_ready
);
reg slow;
reg released;
reg [7:0] since_edge;
initial
begin
   slow = 1'b0;
   released = 1'b0;
   since_edge = 8'h00;
   o_sync_n = 1'b1;
   o_data_ready = 1'b0;
end
always @(posedge i_sys_clk)
begin
   slow <= ~slow;
   o_sync_n <= ~i_resync;
   since_edge <= i_mf_edge ? 8'h00 : since_edge + 8'h01;
   // All lanes have arrived once the link carries data; until then no release
   if (i_link_state != 2'h3)
      released <= 1'b0;
   // Release on the edge plus RBD cycles, which lies clear of the lane arrival spread
   else if ((RBD == 0 && i_mf_edge) || (RBD != 0 && since_edge == RBD - 1))
      released <= 1'b1;
   // Mode 2 stalls, mode 1 takes a word only every other cycle
   o_data_ready <= released && ((i_mode == 2'h0) || (i_mode == 2'h1 && slow));
end
endmodule // slmon_rx_model

/* File: verification/testbench.sv */
// Bench for the link enable, alarm monitor and output buffer
`timescale 1ns/100ps
module testbench;
logic clk = 0, rst = 1, en = 0, s8 = 0, sc1 = 1, sref = 0, cpl = 1, spl = 1;
logic ca = 0, sel = 1, dv = 0, resync = 0, rdy, ov, drdy, lrst, pd, cen, edg, alm, pin, sync_n;
logic cb = 0, pda = 0, pdb = 0, oth = 0;
logic [1:0] ferr = 0, fclr = 0, mode = 2, st, lfa;
logic [5:0] aclr = 0, mask = 0, ast;
logic [7:0] din = 0, dout, cnt, c1;
logic [7:0] q[$];
logic [7:0] w[3] = '{8'hA1, 8'hB2, 8'hC3};
int error_cnt = 0, num_checks = 0, i;
always #20 clk = ~clk;
slmon_top #(.LANES(2), .DW(8), .FRAME_DIV(2), .MF_LEN_8B(4), .EMB_LEN_64B(4)) dut
(
   .i_sys_clk(clk), .i_rst(rst), .i_link_enable(en), .i_sel_8b10b(s8), .i_subclass1(sc1),
   .i_sysref(sref), .i_sync_n(sync_n), .i_cpll_locked(cpl), .i_spll_locked(spl),
   .i_chan_a_clk(ca), .i_chan_b_clk(cb), .i_powerdown_chan_a(pda), .i_powerdown_chan_b(pdb),
   .i_lane_fifo_err(ferr), .i_alarm_status_clear(aclr), .i_lane_fifo_alarm_clear(fclr),
   .i_alarm_mask(mask), .i_cal_status_sel_alarm(sel), .i_cal_status_other(oth),
   .i_data(din), .i_data_valid(dv), .o_data_ready(rdy), .o_data(dout), .o_data_valid(ov),
   .i_data_ready(drdy), .o_link_reset(lrst), .o_serializer_powerdown(pd),
   .o_link_clk_enable(cen), .o_link_state(st), .o_mf_edge(edg), .o_mf_count(cnt),
   .o_alarm_status(ast), .o_lane_fifo_alarm(lfa), .o_alarm(alm), .o_cal_status_pin(pin)
);
slmon_rx_model rx (.i_sys_clk(clk), .i_mode(mode), .i_resync(resync), .i_mf_edge(edg),
   .i_link_state(st), .o_sync_n(sync_n), .o_data_ready(drdy));
// Ready is driven just after the rising edge, so the falling edge sees a settled handshake
always @(negedge clk)
   if (ov === 1'b1 && drdy === 1'b1)
      q.push_back(dout);
////////////////////////////////////////
task final_report;
   $display("checks %0d errors %0d", num_checks, error_cnt);
   if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
   else
      $display("== FAILED ==");
   $finish;
endtask
task chk(string n, logic [7:0] e, logic [7:0] g);
   num_checks++;
   if (g !== e)
   begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
   end
endtask
task cyc(int n);
   repeat (n) @(negedge clk);
endtask
task wst(logic [1:0] s);
   int k;
   for (k = 0; k < 200 && st !== s; k++)
      cyc(1);
   chk("state", s, st);
   if (st !== s)
      final_report();
endtask
// Ready is registered, so its value at the falling edge is what the next rising edge takes
task put(logic [7:0] d);
   int k;
   logic r;
   din = d;
   dv = 1;
   r = 0;
   for (k = 0; k < 100 && !r; k++)
   begin
      r = rdy;
      cyc(1);
   end
   chk("taken", 1, r);
   if (!r)
      final_report();
endtask
////////////////////////////////////////
initial
begin
   cyc(2);
   rst = 0;
   chk("reset", 1, lrst);
   chk("pwdn", 1, pd);
   en = 1;
   wst(3);
   chk("clken", 1, cen);
   for (i = 0; i < 8 && cnt === 8'h00; i++)
      cyc(1);
   sref = 1;
   cyc(1);
   sref = 0;
   chk("mfcount", 0, cnt);
   chk("realign", 8'h08, ast & 6'h08);
   aclr = 6'h3F;
   cyc(1);
   aclr = 0;
   chk("status", 0, ast);
   $display("test link start done");
   put(8'hA1);
   din = 8'hB2;
   cyc(3);
   chk("refuse", 0, rdy);
   mode = 1;
   put(8'hB2);
   put(8'hC3);
   dv = 0;
   cyc(12);
   foreach (w[k])
      chk("word", w[k], q[k]);
   chk("words", 3, q.size());
   $display("test stream done");
   cpl = 0;
   spl = 0;
   cyc(1);
   cpl = 1;
   spl = 1;
   cyc(2);
   chk("pll", 6'h03, ast);
   chk("summary", 1, alm);
   chk("pin", 1, pin);
   mask = 6'h03;
   cyc(1);
   chk("masked", 0, alm);
   chk("pinmask", 0, pin);
   aclr = 6'h01;
   cyc(1);
   aclr = 0;
   mask = 0;
   chk("clear1", 6'h02, ast);
   aclr = 6'h3F;
   ca = 1;
   cyc(1);
   aclr = 0;
   cyc(1);
   ca = 0;
   cyc(2);
   chk("upset", 6'h10, ast);
   ferr = 2'h2;
   cyc(1);
   ferr = 0;
   cyc(1);
   chk("lane", 2'h2, lfa);
   chk("fifo", 6'h30, ast);
   aclr = 6'h3F;
   fclr = 2'h3;
   cyc(1);
   aclr = 0;
   fclr = 0;
   chk("laneclr", 0, lfa);
   chk("allclr", 0, ast);
   pda = 1;
   ca = 1;
   cyc(2);
   pda = 0;
   pdb = 1;
   cyc(2);
   pdb = 0;
   cb = 1;
   cyc(2);
   chk("pdnoalm", 0, ast);
   ca = 0;
   cb = 0;
   aclr = 6'h10;
   sel = 0;
   oth = 1;
   cyc(1);
   aclr = 0;
   chk("pinother", 1, pin);
   sel = 1;
   oth = 0;
   $display("test alarms done");
   en = 0;
   cyc(2);
   chk("off", 0, st);
   chk("pwdn2", 1, pd);
   s8 = 1;
   sc1 = 0;
   resync = 1;
   en = 1;
   wst(1);
   // Right after a frame step the count holds one cycle, so an honoured SYSREF would show
   for (i = 0; i < 20 && cnt !== 8'h02; i++)
      cyc(1);
   c1 = cnt;
   chk("cnt2", 2, c1);
   sref = 1;
   cyc(1);
   sref = 0;
   chk("freerun", c1, cnt);
   chk("norealign", 0, ast & 6'h08);
   for (i = 0; i < 20 && edg !== 1'b1; i++)
      cyc(1);
   chk("edge", 1, edg);
   chk("edgecnt", 0, cnt);
   resync = 0;
   wst(2);
   wst(3);
   $display("test subclass0 done");
   final_report();
end
endmodule // testbench
